// ---- psv_cfg.svh ----
`ifndef PSV_CFG_SVH
`define PSV_CFG_SVH

// ==========================================================
// register map (data addresses)
`define PSV_ADDR_PC_LOW 8'h06
`define PSV_ADDR_TAB_PTR_LO 8'h07
`define PSV_ADDR_TAB_HIGH 8'h08
`define PSV_ADDR_TAB_PTR_HI 8'h1f

// ==========================================================
// reset values
`define PSV_PC_RESET 14'h0000
`define PSV_REG_RESET 8'h00
`define PSV_READ_ZERO 8'h00

// ==========================================================
// interrupt vectors, lowest address has priority
`define PSV_VEC_EXT 14'h0004
`define PSV_VEC_TMR0 14'h0008
`define PSV_VEC_TMR1 14'h000c
`define PSV_VEC_UART 14'h0010
`define PSV_VEC_I2C 14'h0014
`define PSV_VEC_MULTI 14'h0018

// ==========================================================
// field layout and sequencing constants
`define PSV_BANK_BIT 5
`define PSV_LAST_PAGE 6'h3f
`define PSV_PHASE_LAST 2'h3
`define PSV_PHASE_FIRST 2'h0
`define PSV_STACK_LEVELS 16
`define PSV_INT_SOURCES 6

// ==========================================================
// start-up wait, in system clock periods
`define PSV_TSST_TSYS 1024
`define PSV_CLK_PER_TSYS 1
`define PSV_TSST_CYCLES (`PSV_TSST_TSYS * `PSV_CLK_PER_TSYS)

`endif

// ---- psv_pkg.sv ----
package psv_pkg;

  // ==========================================================
  // sequencer mode
  typedef enum logic [1:0] {
    PSV_WAIT,
    PSV_RUN,
    PSV_HALT
  } psv_mode_t;

  // ==========================================================
  // what the current instruction cycle is used for
  typedef enum logic [1:0] {
    PSV_SLOT_EXEC,
    PSV_SLOT_DUMMY,
    PSV_SLOT_TABLE
  } psv_slot_t;

endpackage

// ---- psv_sequencer.sv ----
// Functional notes
// - four clock phases per instruction cycle
// - fetch overlaps execute; branches add dummy cycle
// - 14-bit program counter, increments after fetch
// - reset loads program counter with zero
// - external interrupt vectors to 004H
// - timer 0 overflow vectors to 008H
// - timer 1 overflow vectors to 00CH
// - serial port interrupt vectors to 010H
// - two-wire slave interrupt vectors to 014H
// - multi-function interrupt vectors to 018H
// - taken skip discards prefetch, stays in bank
// - low counter byte write jumps within page
// - jump/call uses field plus bank bit
// - returns restore all fourteen counter bits
// - table address from pointers or last page
// - table read fills low dest and high register
// - table reads take two instruction cycles
// - 1024-clock start-up wait after reset/wake
// - full stack withholds interrupt acknowledge
// - sixteen-level hidden return stack
// - entering service clears global interrupt enable
`include "psv_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module psv_sequencer
  import psv_pkg::*;
#(
  parameter int START_CYCLES = `PSV_TSST_CYCLES,
  parameter int STACK_DEPTH = `PSV_STACK_LEVELS
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic [13:0] prog_addr,
  input wire logic [15:0] prog_data,
  output logic [15:0] instr_word,
  output logic instr_exec,
  output logic [1:0] cycle_phase,
  output logic cycle_end,
  input wire logic ctl_jump,
  input wire logic ctl_call,
  input wire logic ctl_return,
  input wire logic ctl_int_return,
  input wire logic ctl_skip,
  input wire logic ctl_halt,
  input wire logic [12:0] ctl_target,
  input wire logic ctl_tab_paged,
  input wire logic ctl_tab_last,
  input wire logic [7:0] ctl_tab_dest,
  input wire logic [7:0] bank_pointer,
  input wire logic wake,
  input wire logic [5:0] int_req,
  input wire logic [5:0] int_en,
  input wire logic global_interrupt_enable,
  output logic global_interrupt_enable_clr,
  output logic int_return_done,
  output logic [5:0] int_ack,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic tab_wr,
  output logic [7:0] tab_wr_addr,
  output logic [7:0] tab_wr_data
);

  localparam int SPW = $clog2(STACK_DEPTH + 1);
  localparam int SIW = $clog2(STACK_DEPTH);

  // ==========================================================
  // priority pick and vector lookup
  function automatic logic [2:0] psv_pick(input logic [5:0] pend);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = `PSV_INT_SOURCES - 1; i >= 0; i--) begin
      if (pend[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [13:0] psv_vector(input logic [2:0] idx);
    case (idx)
      3'h0: return `PSV_VEC_EXT;
      3'h1: return `PSV_VEC_TMR0;
      3'h2: return `PSV_VEC_TMR1;
      3'h3: return `PSV_VEC_UART;
      3'h4: return `PSV_VEC_I2C;
      default: return `PSV_VEC_MULTI;
    endcase
  endfunction

  // ==========================================================
  // state
  psv_mode_t mode_q;
  psv_slot_t slot_q, slot_d;
  logic [1:0] phase_q;
  logic [$clog2(START_CYCLES + 1)-1:0] wait_q;
  logic [13:0] pc_q, pc_d;
  logic [13:0] addr_q, addr_d;
  logic [15:0] ir_q, ir_d;
  logic [13:0] stack_q [STACK_DEPTH];
  logic [SPW-1:0] depth_q;
  logic [7:0] tab_ptr_lo_q, tab_ptr_hi_q, tab_high_q, pc_low_q, dest_q, rdata_q;
  logic pc_low_pend_q;
  logic tab_wr_q;
  logic [7:0] tab_data_q;
  logic [5:0] ack_q;
  logic gie_clr_q, iret_q;

  logic boundary, exec, full, push, pop, int_take, pc_low_wr, pc_low_go;
  logic [5:0] pend;
  logic [2:0] pick;
  logic [7:0] pc_low_val;
  logic [13:0] tab_addr, stack_top;

  assign boundary = (mode_q == PSV_RUN) && (phase_q == `PSV_PHASE_LAST);
  assign exec = (slot_q == PSV_SLOT_EXEC);
  assign full = (depth_q == SPW'(STACK_DEPTH));
  assign pend = int_req & int_en;
  assign pick = psv_pick(pend);
  assign pc_low_wr = reg_wr && (reg_addr == `PSV_ADDR_PC_LOW);
  assign pc_low_val = pc_low_wr ? reg_wdata : pc_low_q;
  assign pc_low_go = exec && (pc_low_pend_q || pc_low_wr);
  assign stack_top = stack_q[SIW'(depth_q - SPW'(1))];
  // table address: paged uses high pointer, last page forces ones
  assign tab_addr = ctl_tab_last ? {`PSV_LAST_PAGE, tab_ptr_lo_q} :
                    {tab_ptr_hi_q[5:0], tab_ptr_lo_q};
  // no interrupt while the instruction itself changes flow
  assign int_take = boundary && exec && global_interrupt_enable && (|pend) && !full &&
                    !(ctl_jump || ctl_call || ctl_return || ctl_int_return || ctl_skip ||
                      pc_low_go || ctl_tab_paged || ctl_tab_last || ctl_halt);
  assign push = boundary && exec && (ctl_call || int_take);
  assign pop = boundary && exec && (ctl_return || ctl_int_return) && (depth_q != '0);

  // ==========================================================
  // next fetch address and pipeline slot
  always_comb begin
    pc_d = pc_q;
    addr_d = addr_q;
    ir_d = ir_q;
    slot_d = slot_q;
    if (boundary) begin
      case (slot_q)
        PSV_SLOT_TABLE: begin
          // held instruction runs now, fetch resumes at pc
          addr_d = pc_q;
          slot_d = PSV_SLOT_EXEC;
        end
        default: begin
          ir_d = prog_data;
          slot_d = PSV_SLOT_DUMMY;
          if (exec && (ctl_jump || ctl_call)) begin
            pc_d = {bank_pointer[`PSV_BANK_BIT], ctl_target};
          end else if (exec && (ctl_return || ctl_int_return)) begin
            pc_d = stack_top;
          end else if (exec && ctl_skip) begin
            pc_d = {pc_q[13], pc_q[12:0] + 13'h1};
          end else if (pc_low_go) begin
            pc_d = {pc_q[13:8], pc_low_val};
          end else if (exec && (ctl_tab_paged || ctl_tab_last)) begin
            pc_d = pc_q + 14'h1;
            slot_d = PSV_SLOT_TABLE;
          end else if (int_take) begin
            pc_d = psv_vector(pick);
          end else begin
            pc_d = pc_q + 14'h1;
            slot_d = PSV_SLOT_EXEC;
          end
          addr_d = (slot_d == PSV_SLOT_TABLE) ? tab_addr : pc_d;
        end
      endcase
    end
  end

  // ==========================================================
  // start-up wait, halt and phase counter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_q <= PSV_WAIT;
      wait_q <= '0;
      phase_q <= `PSV_PHASE_FIRST;
    end else begin
      case (mode_q)
        PSV_WAIT: begin
          phase_q <= `PSV_PHASE_FIRST;
          if (wait_q == ($bits(wait_q))'(START_CYCLES - 1)) begin
            mode_q <= PSV_RUN;
          end else begin
            wait_q <= wait_q + 1'b1;
          end
        end
        PSV_RUN: begin
          phase_q <= phase_q + 2'h1;
          if (boundary && exec && ctl_halt) begin
            mode_q <= PSV_HALT;
          end
        end
        PSV_HALT: begin
          phase_q <= `PSV_PHASE_FIRST;
          wait_q <= '0;
          if (wake) begin
            mode_q <= PSV_WAIT;
          end
        end
        default: mode_q <= PSV_WAIT;
      endcase
    end
  end

  // ==========================================================
  // program counter and fetch pipeline
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pc_q <= `PSV_PC_RESET;
      addr_q <= `PSV_PC_RESET;
      ir_q <= '0;
      slot_q <= PSV_SLOT_DUMMY;
    end else begin
      pc_q <= pc_d;
      addr_q <= addr_d;
      ir_q <= ir_d;
      slot_q <= slot_d;
    end
  end

  // ==========================================================
  // return stack, not visible to software
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      depth_q <= '0;
    end else if (push) begin
      // a call on a full stack overwrites the oldest level
      stack_q[SIW'(depth_q)] <= pc_q;
      if (!full) begin
        depth_q <= depth_q + SPW'(1);
      end
    end else if (pop) begin
      depth_q <= depth_q - SPW'(1);
    end
  end

  // ==========================================================
  // interrupt acknowledge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_q <= '0;
      gie_clr_q <= 1'b0;
      iret_q <= 1'b0;
    end else begin
      ack_q <= int_take ? (6'h01 << pick) : 6'h00;
      gie_clr_q <= int_take;
      iret_q <= boundary && exec && ctl_int_return;
    end
  end

  // ==========================================================
  // data-side registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tab_ptr_lo_q <= `PSV_REG_RESET;
      tab_ptr_hi_q <= `PSV_REG_RESET;
      pc_low_q <= `PSV_REG_RESET;
      pc_low_pend_q <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == `PSV_ADDR_TAB_PTR_LO)) begin
        tab_ptr_lo_q <= reg_wdata;
      end
      if (reg_wr && (reg_addr == `PSV_ADDR_TAB_PTR_HI)) begin
        tab_ptr_hi_q <= reg_wdata;
      end
      if (pc_low_wr) begin
        pc_low_q <= reg_wdata;
      end
      // a write landing on the boundary is consumed there
      pc_low_pend_q <= pc_low_wr ? !boundary : (pc_low_pend_q && !boundary);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= `PSV_READ_ZERO;
    end else begin
      case (reg_addr)
        `PSV_ADDR_PC_LOW: rdata_q <= pc_q[7:0];
        `PSV_ADDR_TAB_PTR_LO: rdata_q <= tab_ptr_lo_q;
        `PSV_ADDR_TAB_HIGH: rdata_q <= tab_high_q;
        `PSV_ADDR_TAB_PTR_HI: rdata_q <= tab_ptr_hi_q;
        default: rdata_q <= `PSV_READ_ZERO;
      endcase
    end
  end

  // ==========================================================
  // table read completion
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tab_high_q <= `PSV_REG_RESET;
      dest_q <= `PSV_REG_RESET;
      tab_data_q <= `PSV_REG_RESET;
      tab_wr_q <= 1'b0;
    end else begin
      tab_wr_q <= 1'b0;
      if (boundary && exec && (ctl_tab_paged || ctl_tab_last)) begin
        dest_q <= ctl_tab_dest;
      end
      if (boundary && (slot_q == PSV_SLOT_TABLE)) begin
        tab_high_q <= prog_data[15:8];
        tab_data_q <= prog_data[7:0];
        tab_wr_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // outputs
  assign prog_addr = addr_q;
  assign instr_word = ir_q;
  assign instr_exec = (mode_q == PSV_RUN) && exec;
  assign cycle_phase = phase_q;
  assign cycle_end = boundary;
  assign int_ack = ack_q;
  assign global_interrupt_enable_clr = gie_clr_q;
  assign int_return_done = iret_q;
  assign reg_rdata = rdata_q;
  assign tab_wr = tab_wr_q;
  assign tab_wr_addr = dest_q;
  assign tab_wr_data = tab_data_q;

endmodule // psv_sequencer

`default_nettype wire

// ---- psv_seq_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// sequencer port checks
module psv_seq_props #(
  parameter int START_CYCLES = 1024
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [13:0] prog_addr,
  input wire logic instr_exec,
  input wire logic [1:0] cycle_phase,
  input wire logic cycle_end,
  input wire logic ctl_halt,
  input wire logic ctl_tab_paged,
  input wire logic ctl_tab_last,
  input wire logic [5:0] int_req,
  input wire logic [5:0] int_en,
  input wire logic global_interrupt_enable,
  input wire logic global_interrupt_enable_clr,
  input wire logic [5:0] int_ack,
  input wire logic tab_wr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // clocks since reset, saturating
  logic [15:0] cnt_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q != 16'hffff) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  property p_phase;
    cycle_end && !(instr_exec && ctl_halt) |-> cycle_phase == 2'h3 ##1 !cycle_end [*3] ##1 cycle_end;
  endproperty
  a_phase: assert property (p_phase) else $error("cycle spacing wrong");
  property p_hold;
    !cycle_end |=> $stable(prog_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("fetch address moved");
  property p_vec;
    int_ack != 6'h00 |-> $onehot(int_ack) && prog_addr[13:5] == 9'h000 && prog_addr[1:0] == 2'h0
      && int_ack[prog_addr[4:2] - 3'h1];
  endproperty
  a_vec: assert property (p_vec) else $error("vector does not match ack");
  property p_clr;
    int_ack != 6'h00 |-> global_interrupt_enable_clr ##1 !global_interrupt_enable_clr;
  endproperty
  a_clr: assert property (p_clr) else $error("enable clear pulse wrong");
  property p_dummy;
    int_ack != 6'h00 |-> !instr_exec [*4] ##1 instr_exec;
  endproperty
  a_dummy: assert property (p_dummy) else $error("no dummy cycle");
  property p_prio;
    int_ack != 6'h00 |-> $past(global_interrupt_enable)
      && (($past(int_req) & $past(int_en)) & (int_ack - 6'h01)) == 6'h00;
  endproperty
  a_prio: assert property (p_prio) else $error("wrong interrupt chosen");
  property p_table;
    cycle_end && instr_exec && (ctl_tab_paged || ctl_tab_last) |=> !instr_exec ##3 cycle_end ##1 tab_wr;
  endproperty
  a_table: assert property (p_table) else $error("table read length wrong");
  property p_start;
    cycle_end |-> cnt_q >= START_CYCLES;
  endproperty
  a_start: assert property (p_start) else $error("ran before start-up wait");
  c_ack: cover property (int_ack != 6'h00);
  c_tab: cover property (tab_wr);
  c_dummy: cover property (cycle_end && !instr_exec);
endmodule // psv_seq_props
bind psv_sequencer psv_seq_props #(.START_CYCLES(START_CYCLES)) psv_seq_props_i (
  .clock, .rst_n, .prog_addr, .instr_exec, .cycle_phase, .cycle_end, .ctl_halt, .ctl_tab_paged,
  .ctl_tab_last, .int_req, .int_en, .global_interrupt_enable, .global_interrupt_enable_clr,
  .int_ack, .tab_wr);
`default_nettype wire

// ---- psv_prog_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// program memory and interrupt sources
module psv_prog_mem (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [13:0] prog_addr,
  output logic [15:0] prog_data,
  input wire logic [5:0] raise,
  input wire logic [5:0] int_ack,
  input wire logic gie_clr,
  input wire logic irq_done,
  output logic [5:0] req_q,
  output logic gie_q
);
  // each word carries its own address
  assign prog_data = {2'h2, prog_addr};
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_q <= 6'h00;
      gie_q <= 1'b1;
    end else begin
      req_q <= (req_q | raise) & ~int_ack;
      if (gie_clr) begin
        gie_q <= 1'b0;
      end else if (irq_done) begin
        gie_q <= 1'b1;
      end
    end
  end
endmodule // psv_prog_mem
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// sequencer testbench
module tb_top;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} psv_row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic instr_exec, cycle_end, gie, gie_clr, irq_done, tab_wr;
  logic wake = 1'b0;
  logic [1:0] phase;
  logic [13:0] prog_addr, pa, return_pa;
  logic [15:0] prog_data, instr_word;
  logic [7:0] ctl = 8'h00;
  logic [7:0] bank_pointer = 8'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, tab_wr_addr, tab_wr_data;
  logic [12:0] ctl_target = 13'h0000;
  logic [5:0] raise = 6'h00;
  logic [5:0] int_req, int_ack;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  psv_row_t rows [4] = '{'{8'h07, 8'h34, 8'h34}, '{8'h1f, 8'h05, 8'h05},
    '{8'h08, 8'h77, 8'h00}, '{8'h20, 8'h66, 8'h00}};
  psv_sequencer #(.START_CYCLES(8), .STACK_DEPTH(16)) psv_sequencer_i (
    .clock, .rst_n, .prog_addr, .prog_data, .instr_word, .instr_exec, .cycle_phase(phase),
    .cycle_end, .ctl_jump(ctl[7]), .ctl_call(ctl[6]), .ctl_return(ctl[5]),
    .ctl_int_return(ctl[4]),
    .ctl_skip(ctl[3]), .ctl_halt(ctl[2]), .ctl_tab_paged(ctl[1]), .ctl_tab_last(ctl[0]),
    .ctl_target, .ctl_tab_dest(8'h44), .bank_pointer, .wake, .int_req, .int_en(6'h3f),
    .global_interrupt_enable(gie), .global_interrupt_enable_clr(gie_clr),
    .int_return_done(irq_done), .int_ack,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .tab_wr, .tab_wr_addr, .tab_wr_data);
  psv_prog_mem psv_prog_mem_i (.clock, .rst_n, .prog_addr, .prog_data, .raise, .int_ack,
    .gie_clr, .irq_done, .req_q(int_req), .gie_q(gie));
  initial begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc > 4000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  // present controls for the next executing boundary
  task automatic op(input logic [7:0] c);
    while (!(cycle_end === 1'b1 && instr_exec === 1'b1)) begin
      @(negedge clock);
    end
    pa = prog_addr;
    chk("cycle_phase", {14'h0000, phase}, 16'h0003);
    ctl = c;
    @(negedge clock);
    ctl = 8'h00;
  endtask
  task automatic irq(input logic [5:0] m);
    raise = m;
    @(negedge clock);
    raise = 6'h00;
    op(8'h00);
  endtask
  initial begin
    repeat (2) @(negedge clock);
    chk("prog_addr", prog_addr, 16'h0000);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      @(negedge clock);
      chk("reg_rdata", reg_rdata, rows[i].e);
    end
    op(8'h00);
    chk("prog_addr", prog_addr, 16'h0002);
    chk("instr_word", instr_word, 16'h8001);
    bank_pointer = 8'h20;
    ctl_target = 13'h1ffe;
    op(8'h80);
    chk("prog_addr", prog_addr, 16'h3ffe);
    chk("instr_exec", instr_exec, 16'h0000);
    op(8'h08);
    chk("prog_addr", prog_addr, 16'h2000);
    bank_pointer = 8'h00;
    ctl_target = 13'h0040;
    op(8'h40);
    return_pa = pa;
    chk("prog_addr", prog_addr, 16'h0040);
    op(8'h00);
    wr(8'h06, 8'h9a);
    op(8'h00);
    chk("prog_addr", prog_addr, 16'h009a);
    op(8'h20);
    chk("prog_addr", prog_addr, {2'h0, return_pa});
    op(8'h02);
    chk("prog_addr", prog_addr, 16'h0534);
    repeat (4) @(negedge clock);
    chk("tab_wr", tab_wr, 16'h0001);
    chk("tab_wr_data", {tab_wr_addr, tab_wr_data}, 16'h4434);
    reg_addr = 8'h08;
    @(negedge clock);
    chk("reg_rdata", reg_rdata, 16'h0085);
    op(8'h01);
    chk("prog_addr", prog_addr, 16'h3f34);
    for (int k = 0; k < 6; k++) begin
      irq(6'h01 << k);
      chk("prog_addr", prog_addr, 16'(4 * k + 4));
      chk("int_ack", int_ack, 16'(1 << k));
      op(8'h10);
    end
    irq(6'h24);
    chk("prog_addr", prog_addr, 16'h000c);
    op(8'h00);
    chk("prog_addr", prog_addr, {2'h0, pa + 14'h0001});
    op(8'h10);
    op(8'h00);
    chk("prog_addr", prog_addr, 16'h0018);
    op(8'h04);
    repeat (12) @(negedge clock);
    chk("instr_exec", instr_exec, 16'h0000);
    wake = 1'b1;
    @(negedge clock);
    wake = 1'b0;
    repeat (7) @(negedge clock);
    chk("instr_exec", instr_exec, 16'h0000);
    op(8'h00);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    chk("prog_addr", prog_addr, 16'h0000);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
